// file: epm_energy_pulse.sv
// Purpose: Energy pulse FIFO, pulse outputs and live RAM monitor
// Assumes: ref_clk is the filter clock; engine strobes are one cycle
// Notes:   APB slave, zero wait states
//
// Operation
// - Stream four watched RAM words each pass
// - Monitor runs only while enable set
// - 35 bits per word, flag first, clock pin
// - Monitor data held low when idle
// - Four pulses, each can request interrupt
// - Polarity bit inverts all pulse outputs
// - Zero-cross and sag change once per pass
// - Energy sign bits stored in 8-entry FIFO
// - FIFO cleared at each frame start
// - Interval sets first delay and spacing
// - Zero interval bypasses the FIFO
// - Width limited to (2w+1) times interval
// - Width 255 or interval 0: no limit
// - Default polarity gives low-going pulses
// - Real energy pulse routable to optical transmit pin
// - One ADC sample per channel per frame
// - Sample count sets accumulation; transfer irq
// - Frame end signalled by engine-busy irq
// - Halt clears engine-busy and transfer-busy
// - Zero-cross and sag irq on leading edge
`timescale 1ns/1ps
module epm_energy_pulse
   import epm_pkg::*;
#(
   parameter int FIFO_DEPTH = epm_pkg::EPM_FIFO_DEPTH // Entries of sign-bit pairs
)(
   input  wire logic                          ref_clk,          // Filter clock, 100 MHz
   input  wire logic                          rstn,             // Async reset, active low
   input  wire logic                          psel,             // APB select
   input  wire logic                          penable,          // APB access phase
   input  wire logic                          pwrite,           // APB direction
   input  wire logic [15:0]                   paddr,            // APB byte address
   input  wire logic [31:0]                   pwdata,           // APB write data
   output logic      [31:0]                   prdata,           // APB read data
   output logic                               pready,           // APB ready
   output logic                               pslverr,          // APB error
   input  wire logic                          frameStart,       // Mux frame / pass start
   input  wire logic                          engineHalt,       // Engine halt executed
   input  wire logic                          signValid,        // Export strobe
   input  wire logic [1:0]                    signBits,         // {reactive, real}
   input  wire logic [1:0]                    auxBits,          // {sag, zero cross}
   input  wire logic [EPM_WORD_W-1:0]         ramData,          // Watched RAM read data
   output logic      [EPM_RAM_AW-1:0]         ramAddr,          // Watched RAM address
   output logic                               real_energy_pulse,     // Energy pulse pin
   output logic                               reactive_energy_pulse, // Energy pulse pin
   output logic                               zero_cross_pulse, // Aux pulse pin
   output logic                               sag_pulse,        // Aux pulse pin
   output logic                               optical_transmit_pin, // Optical output
   output logic                               test_mux_data_pin,    // Monitor data
   output logic                               test_mux_clock_pin,   // Monitor clock
   output logic      [3:0]                    pulseIrq,         // Pulse irq requests
   output logic                               engineBusyIrq,    // Frame end request
   output logic                               transfer_busy_irq // Accumulation done
);
   import epm_pkg::*;

   initial begin
      if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16) $error("FIFO_DEPTH out of range");
   end
   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int WW = 19; // Holds (2*254+1)*1020, the longest width limit

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  monCfg, pulse_max_width, pulse_update_interval;
   logic        pulse_polarity_invert;
   logic [1:0]  optical_output_select;
   logic [12:0] accumulation_sample_count;
   logic [EPM_RAM_AW-1:0] monAddr [EPM_MON_WORDS];
   logic [12:0] frameCount;
   logic        monBusy;

   wire  apbWr    = psel && penable && pwrite;
   wire  apbRd    = psel && !penable && !pwrite;
   wire  hitCfg   = paddr == EPM_OFS_MONCFG;
   // Sample count spans two byte-wide registers
   wire  hitSumHi = paddr == EPM_OFS_SUMHI;
   wire  hitSumLo = paddr == EPM_OFS_SUMLO;
   wire  hitMaxw  = paddr == EPM_OFS_MAXW;
   wire  hitIntv  = paddr == EPM_OFS_INTV;
   wire  hitPol   = paddr == EPM_OFS_POL;
   wire  hitOpt   = paddr == EPM_OFS_OPT;
   wire  hitStat  = paddr == EPM_OFS_STAT;
   wire  hitMadr  = paddr[15:4] == EPM_OFS_MONADR[15:4] && paddr[1:0] == 2'h0;
   wire  [1:0] madrIdx = paddr[3:2];
   wire  hitAny   = hitCfg | hitSumHi | hitSumLo | hitMaxw | hitIntv | hitPol |
                    hitOpt | hitStat | hitMadr;
   wire  monEnable = monCfg[EPM_MON_EN_BIT];

   // Read mux; unmapped reads return zero with error
   logic [31:0] rdMux;
   assign rdMux = hitCfg  ? {24'h0, monCfg} :
                  hitSumHi ? {27'h0, accumulation_sample_count[12:EPM_SUM_LO_W]} :
                  hitSumLo ? {24'h0, accumulation_sample_count[EPM_SUM_LO_W-1:0]} :
                  hitMaxw ? {24'h0, pulse_max_width} :
                  hitIntv ? {24'h0, pulse_update_interval} :
                  hitPol  ? {31'h0, pulse_polarity_invert} :
                  hitOpt  ? {28'h0, optical_output_select, 2'h0} :
                  hitStat ? {18'h0, monBusy, frameCount} :
                  hitMadr ? {20'h0, monAddr[madrIdx]} : 32'h0;

   // Register writes take effect in the access phase
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         monCfg <= 8'h0;
         pulse_max_width <= EPM_WIDTH_NOLIM;
         pulse_update_interval <= 8'h0;
         pulse_polarity_invert <= 1'b0;
         optical_output_select <= 2'h0;
         accumulation_sample_count <= 13'h0;
         for (int i = 0; i < EPM_MON_WORDS; i++) monAddr[i] <= '0;
      end else if (apbWr) begin
         if (hitCfg)  monCfg <= pwdata[7:0];
         if (hitSumHi) accumulation_sample_count[12:EPM_SUM_LO_W] <= pwdata[12-EPM_SUM_LO_W:0];
         if (hitSumLo) accumulation_sample_count[EPM_SUM_LO_W-1:0] <= pwdata[EPM_SUM_LO_W-1:0];
         if (hitMaxw) pulse_max_width <= pwdata[7:0];
         if (hitIntv) pulse_update_interval <= pwdata[7:0];
         if (hitPol)  pulse_polarity_invert <= pwdata[EPM_POL_BIT];
         if (hitOpt)  optical_output_select <= pwdata[EPM_OPT_LO +: 2];
         if (hitMadr) monAddr[madrIdx] <= pwdata[EPM_RAM_AW-1:0];
      end
   end

   // APB answer: ready in every access phase, data captured in setup
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hitAny;
         if (apbRd) prdata <= rdMux;
      end
   end

   // ------------------------------------------------------------
   // Energy pulse FIFO and release timing
   // ------------------------------------------------------------
   logic [1:0]  fifoMem [FIFO_DEPTH];
   logic [PW:0] wrPtr, rdPtr;
   logic [9:0]  tickCnt;
   logic [WW-1:0] widthCnt;
   logic [1:0]  energyLvl;
   wire  bypass   = pulse_update_interval == 8'h0;
   wire  fifoFull = (wrPtr - rdPtr) == (PW+1)'(FIFO_DEPTH);
   wire  fifoEmpty = wrPtr == rdPtr;
   wire  [9:0]  intervalTicks = 10'(pulse_update_interval) * 10'(EPM_TICKS_PER_LSB);
   wire  release_ = !bypass && tickCnt == 10'h1 && !frameStart;
   wire  noLimit  = bypass || pulse_max_width == EPM_WIDTH_NOLIM;
   wire  [WW-1:0] maxTicks = (WW'(pulse_max_width) * WW'(2) + WW'(1)) *
                             WW'(intervalTicks);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         tickCnt <= 10'h0;
      end else if (frameStart) begin
         wrPtr <= '0;
         rdPtr <= '0;
         tickCnt <= intervalTicks;
      end else begin
         if (signValid && !bypass && !fifoFull) begin
            fifoMem[wrPtr[PW-1:0]] <= signBits;
            wrPtr <= wrPtr + 1'b1;
         end
         if (release_) begin
            tickCnt <= intervalTicks;
            if (!fifoEmpty) rdPtr <= rdPtr + 1'b1;
         end else if (tickCnt != 10'h0) begin
            tickCnt <= tickCnt - 1'b1;
         end
      end
   end

   // Active-state level per energy pulse; width limit ends a long pulse
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         energyLvl <= 2'h0;
         widthCnt <= '0;
      end else if (bypass) begin
         if (signValid) energyLvl <= signBits;
         widthCnt <= '0;
      end else if (release_ && !fifoEmpty) begin
         energyLvl <= fifoMem[rdPtr[PW-1:0]];
         widthCnt <= '0;
      end else if (!noLimit && energyLvl != 2'h0) begin
         widthCnt <= widthCnt + 1'b1;
         if (widthCnt + 1'b1 >= maxTicks) energyLvl <= 2'h0;
      end
   end

   // Auxiliary pulses latch once per pass
   logic [1:0] auxLvl;
   logic       auxDone;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         auxLvl <= 2'h0;
         auxDone <= 1'b0;
      end else if (frameStart) begin
         auxDone <= 1'b0;
      end else if (signValid && !auxDone) begin
         auxLvl <= auxBits;
         auxDone <= 1'b1;
      end
   end

   // Pins: default polarity gives low-going pulses
   wire [3:0] lvl = {auxLvl, energyLvl};
   logic [3:0] lvlD;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {sag_pulse, zero_cross_pulse, reactive_energy_pulse, real_energy_pulse} <= 4'hf;
         optical_transmit_pin <= 1'b0;
         lvlD <= 4'h0;
         pulseIrq <= 4'h0;
      end else begin
         {sag_pulse, zero_cross_pulse, reactive_energy_pulse, real_energy_pulse}
            <= pulse_polarity_invert ? lvl : ~lvl;
         optical_transmit_pin <= (optical_output_select == EPM_OPT_PULSE) &&
                                 (energyLvl[0] ^ !pulse_polarity_invert);
         lvlD <= lvl;
         pulseIrq <= lvl & ~lvlD;
      end
   end

   // ------------------------------------------------------------
   // Frame events and accumulation
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         frameCount <= 13'h0;
         engineBusyIrq <= 1'b0;
         transfer_busy_irq <= 1'b0;
      end else begin
         if (frameStart) begin
            engineBusyIrq <= 1'b1;
            if (frameCount + 13'h1 >= accumulation_sample_count) begin
               frameCount <= 13'h0;
               transfer_busy_irq <= 1'b1;
            end else begin
               frameCount <= frameCount + 13'h1;
            end
         end else if (engineHalt) begin
            engineBusyIrq <= 1'b0;
            transfer_busy_irq <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Live RAM monitor serialiser
   // ------------------------------------------------------------
   logic [1:0]  wordIdx;
   logic [5:0]  bitCnt;
   logic [34:0] shiftReg;
   logic        monPhase;
   // Registered fetch address points at the word loaded next, so a
   // word boundary never reloads the address of the word just sent
   wire  [1:0] fetchIdx = monBusy ? wordIdx + 2'h1 : 2'h0;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ramAddr <= '0;
      end else begin
         ramAddr <= monAddr[fetchIdx];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         monBusy <= 1'b0;
         wordIdx <= 2'h0;
         bitCnt <= 6'h0;
         shiftReg <= 35'h0;
         monPhase <= 1'b0;
         test_mux_data_pin <= 1'b0;
         test_mux_clock_pin <= 1'b0;
      end else if (!monEnable) begin
         monBusy <= 1'b0;
         test_mux_data_pin <= 1'b0;
         test_mux_clock_pin <= 1'b0;
      end else if (frameStart && !monBusy) begin
         monBusy <= 1'b1;
         wordIdx <= 2'h0;
         bitCnt <= 6'h0;
         monPhase <= 1'b0;
         shiftReg <= {1'b1, ramData, 2'h0};
      end else if (monBusy) begin
         monPhase <= !monPhase;
         test_mux_clock_pin <= monPhase;
         if (!monPhase) begin
            test_mux_data_pin <= shiftReg[34];
            shiftReg <= {shiftReg[33:0], 1'b0};
         end else if (bitCnt == 6'(EPM_MON_BITS - 1)) begin
            bitCnt <= 6'h0;
            wordIdx <= wordIdx + 2'h1;
            shiftReg <= {1'b1, ramData, 2'h0};
            if (wordIdx == 2'(EPM_MON_WORDS - 1)) monBusy <= 1'b0;
         end else begin
            bitCnt <= bitCnt + 6'h1;
         end
      end else begin
         test_mux_data_pin <= 1'b0;
         test_mux_clock_pin <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_fifo_frame_clr: assert property (@(posedge ref_clk) disable iff (!rstn)
      frameStart |=> fifoEmpty) else $error("FIFO not cleared at frame");
   a_bypass_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
      bypass && signValid |=> energyLvl == $past(signBits)) else $error("bypass lag");
   a_mon_idle_low: assert property (@(posedge ref_clk) disable iff (!rstn)
      !monEnable |=> !test_mux_data_pin) else $error("monitor data not low");
   a_halt_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
      engineHalt && !frameStart |=> !engineBusyIrq && !transfer_busy_irq) else $error("halt");
   a_frame_busy: assert property (@(posedge ref_clk) disable iff (!rstn)
      frameStart |=> engineBusyIrq) else $error("no engine busy");
   a_pol_default: assert property (@(posedge ref_clk) disable iff (!rstn)
      !pulse_polarity_invert && energyLvl[0] |=> !real_energy_pulse) else $error("polarity");
   a_irq_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
      pulseIrq[2] |-> $past(auxLvl[0]) && !$past(lvlD[2])) else $error("irq edge");
   a_aux_once: assert property (@(posedge ref_clk) disable iff (!rstn)
      auxDone && !frameStart |=> $stable(auxLvl)) else $error("aux changed twice");
   a_nolimit_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      noLimit && !bypass && !release_ && !frameStart |=> $stable(energyLvl))
      else $error("width limit applied");
   c_release: cover property (@(posedge ref_clk) release_ && !fifoEmpty);
   c_monitor: cover property (@(posedge ref_clk) monBusy && wordIdx == 2'h3);
   c_transfer: cover property (@(posedge ref_clk) $rose(transfer_busy_irq));
   c_width_cut: cover property (@(posedge ref_clk) !noLimit && energyLvl != 2'h0 ##1 energyLvl == 2'h0);
endmodule

// file: epm_far_side.sv
// Purpose: Far-side model: watched RAM and live monitor receiver
// Assumes: monitor data is settled at the rising edge of the clock pin
// Notes:   Bit order of a word is not fixed here; the bench judges it
`timescale 1ns/1ps
module epm_far_side (
   input  wire logic [11:0] ramAddr,  // Watched RAM address
   output logic      [31:0] ramData,  // Watched RAM data
   input  wire logic        monClk,   // Monitor clock pin
   input  wire logic        monData,  // Monitor data pin
   input  wire logic        clear,    // Restart capture
   output logic      [34:0] captured, // First word, first bit on top
   output logic      [7:0]  bitCount  // Bits taken since clear
);
   // ----------------------------------------------------------
   // RAM and receiver
   // ----------------------------------------------------------
   // Data carries the address so a wrong pick shows up
   assign ramData = {20'h5a3c9, ramAddr};
   // Only the first word is kept; later ones just count
   always @(posedge monClk or posedge clear) begin
      if (clear) begin
         bitCount <= 8'h00;
      end else begin
         if (bitCount < 8'd35) begin
            captured <= {captured[33:0], monData};
         end
         bitCount <= bitCount + 8'h01;
      end
   end
endmodule

// file: epm_pkg.sv
// Purpose: Shared constants for the energy pulse and monitor block
// Assumes: one 32-bit word per byte-wide configuration register
// Notes:   APB byte address is four times the register index
package epm_pkg;
   // -------------------------------------------------------------
   // Register indices
   // -------------------------------------------------------------
   localparam logic [15:0] EPM_IDX_MONCFG  = 16'h2106; // Monitor enable, bit 1
   localparam logic [15:0] EPM_IDX_SUMHI   = 16'h2107; // Sample count bits 12:8 in 4:0
   localparam logic [15:0] EPM_IDX_SUMLO   = 16'h2108; // Sample count bits 7:0
   localparam logic [15:0] EPM_IDX_MAXW    = 16'h210a; // pulse_max_width
   localparam logic [15:0] EPM_IDX_INTV    = 16'h210b; // pulse_update_interval
   localparam logic [15:0] EPM_IDX_POL     = 16'h210c; // Polarity invert bit 0
   localparam logic [15:0] EPM_IDX_OPT     = 16'h2456; // Optical select bits 3:2
   localparam logic [15:0] EPM_IDX_STAT    = 16'h2120; // Status, read only, free slot
   localparam logic [15:0] EPM_IDX_MONADR  = 16'h2124; // Four watched addresses, free slots
   // -------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------
   localparam logic [15:0] EPM_OFS_MONCFG  = {EPM_IDX_MONCFG[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_SUMHI   = {EPM_IDX_SUMHI[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_SUMLO   = {EPM_IDX_SUMLO[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_MAXW    = {EPM_IDX_MAXW[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_INTV    = {EPM_IDX_INTV[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_POL     = {EPM_IDX_POL[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_OPT     = {EPM_IDX_OPT[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_STAT    = {EPM_IDX_STAT[13:0], 2'b00};
   localparam logic [15:0] EPM_OFS_MONADR  = {EPM_IDX_MONADR[13:0], 2'b00};
   // -------------------------------------------------------------
   // Field positions and constants
   // -------------------------------------------------------------
   localparam int          EPM_MON_EN_BIT  = 1;
   localparam int          EPM_SUM_LO_W    = 8;      // Low byte of the sample count
   localparam int          EPM_POL_BIT     = 0;
   localparam int          EPM_OPT_LO      = 2;
   localparam logic [1:0]  EPM_OPT_PULSE   = 2'h1;   // Select the real energy pulse
   localparam logic [7:0]  EPM_WIDTH_NOLIM = 8'hff;
   localparam int          EPM_TICKS_PER_LSB = 4;    // Filter cycles per interval count
   localparam int          EPM_MON_BITS    = 35;     // Bits per monitored word, two filter cycles each
   localparam int          EPM_FIFO_DEPTH  = 8;
   localparam int          EPM_RAM_AW      = 12;
   localparam int          EPM_WORD_W      = 32;
   localparam int          EPM_MON_WORDS   = 4;
endpackage

// file: tb_top.sv
// Purpose: Self-checking bench for the energy pulse and monitor block
// Assumes: zero wait APB, pulse pins idle high at default polarity
// Notes:   Each scenario is one task that judges its own outcome
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
   $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   import epm_pkg::*;
   logic ref_clk, rstn, psel, penable, pwrite, frameStart, engineHalt, signValid, clr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, ramData, rdv;
   logic [1:0]  signBits, auxBits;
   logic [11:0] ramAddr;
   logic [3:0]  pulseIrq;
   logic [34:0] cap;
   logic [7:0]  bitCount;
   logic pready, pslverr, errv, realP, reactP, zeroP, sagP, optP, monD, monC, engB, xferB;
   int   mismatches, samples_checked, n;
   epm_energy_pulse dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frameStart(frameStart), .engineHalt(engineHalt),
      .signValid(signValid), .signBits(signBits), .auxBits(auxBits), .ramData(ramData),
      .ramAddr(ramAddr), .real_energy_pulse(realP), .reactive_energy_pulse(reactP),
      .zero_cross_pulse(zeroP), .sag_pulse(sagP), .optical_transmit_pin(optP),
      .test_mux_data_pin(monD), .test_mux_clock_pin(monC), .pulseIrq(pulseIrq),
      .engineBusyIrq(engB), .transfer_busy_irq(xferB));
   epm_far_side far (.ramAddr(ramAddr), .ramData(ramData), .monClk(monC), .monData(monD),
      .clear(clr), .captured(cap), .bitCount(bitCount));
   // ----------------------------------------------------------
   // Clock, bus and strobe tasks
   // ----------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdv = prdata; errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic pulse_in(input logic fs, input logic ht, input logic sv, input logic [1:0] b);
      @(posedge ref_clk);
      frameStart <= fs; engineHalt <= ht; signValid <= sv; signBits <= b;
      @(posedge ref_clk);
      frameStart <= 1'b0; engineHalt <= 1'b0; signValid <= 1'b0;
   endtask
   task automatic cycles(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_regs();
      `CHK({realP, reactP, zeroP, sagP}, 4'hf)
      apb(1'b0, EPM_OFS_MAXW, 32'h0); `CHK(rdv[7:0], EPM_WIDTH_NOLIM)
      apb(1'b0, EPM_OFS_INTV, 32'h0); `CHK(rdv[7:0], 8'h00)
      apb(1'b0, 16'h2200, 32'h0); `CHK({errv, rdv}, {1'b1, 32'h0})
   endtask
   // Bypass: level follows the sign bit, one irq per leading edge
   task automatic t_bypass();
      int c;
      c = 0;
      pulse_in(1'b0, 1'b0, 1'b1, 2'b01);
      for (int i = 0; i < 6; i++) begin cycles(1); c += pulseIrq[0]; end
      `CHK({realP, reactP}, 2'b01)
      `CHK(c, 1)
      apb(1'b1, EPM_OFS_OPT, 32'h4); cycles(3);
      `CHK(optP, realP)
      apb(1'b1, EPM_OFS_POL, 32'h1); cycles(3);
      `CHK({realP, reactP}, 2'b10)
      `CHK(optP, 1'b1)
      apb(1'b1, EPM_OFS_POL, 32'h0);
      pulse_in(1'b0, 1'b0, 1'b1, 2'b00); cycles(4);
      `CHK({realP, reactP}, 2'b11)
   endtask
   // Interval 2 gives 8 cycles to first release, width capped at 8
   task automatic t_fifo();
      apb(1'b1, EPM_OFS_INTV, 32'h2);
      apb(1'b0, EPM_OFS_INTV, 32'h0); `CHK(rdv[7:0], 8'h02)
      apb(1'b1, EPM_OFS_MAXW, 32'h0);
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00);
      pulse_in(1'b0, 1'b0, 1'b1, 2'b01); cycles(3);
      `CHK(realP, 1'b1)
      cycles(5); `CHK(realP, 1'b0)
      cycles(11); `CHK(realP, 1'b1)
      // Second frame start before the release must drop the entry
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00);
      pulse_in(1'b0, 1'b0, 1'b1, 2'b10); cycles(2);
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00);
      n = 0;
      for (int i = 0; i < 16; i++) begin cycles(1); n += (reactP == 1'b0); end
      `CHK(n, 0)
   endtask
   task automatic t_events();
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00); cycles(2);
      `CHK(engB, 1'b1)
      pulse_in(1'b0, 1'b1, 1'b0, 2'b00); cycles(2);
      `CHK({engB, xferB}, 2'b00)
      // Zero-cross takes the first export of a pass only, one irq
      auxBits <= 2'b01; n = 0;
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00);
      pulse_in(1'b0, 1'b0, 1'b1, 2'b00);
      auxBits <= 2'b10;
      for (int i = 0; i < 4; i++) begin cycles(1); n += pulseIrq[2]; end
      pulse_in(1'b0, 1'b0, 1'b1, 2'b00); cycles(2);
      `CHK({sagP, zeroP}, 2'b10)
      `CHK(n, 1)
      // Three frames per accumulation: transfer flag on the third only
      apb(1'b1, EPM_OFS_SUMLO, 32'h3);
      apb(1'b0, EPM_OFS_SUMLO, 32'h0); `CHK(rdv, 32'h3)
      pulse_in(1'b0, 1'b1, 1'b0, 2'b00);
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00);
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00); cycles(2);
      `CHK(xferB, 1'b0)
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00); cycles(2);
      `CHK(xferB, 1'b1)
   endtask
   // Monitor off: data stays low; on: flag then the watched word
   task automatic t_monitor();
      logic [31:0] rv;
      n = 0;
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00);
      for (int i = 0; i < 90; i++) begin cycles(1); n += monD; end
      `CHK(n, 0)
      apb(1'b1, EPM_OFS_MONADR, 32'h123);
      apb(1'b1, EPM_OFS_MONCFG, 32'h2);
      clr <= 1'b1; cycles(1); clr <= 1'b0;
      pulse_in(1'b1, 1'b0, 1'b0, 2'b00); cycles(80);
      for (int i = 0; i < 32; i++) rv[i] = cap[33 - i];
      `CHK(cap[34], 1'b1)
      `CHK(cap[33:2] === 32'h5a3c9123 || rv === 32'h5a3c9123, 1'b1)
      cycles(220); n = 0;
      for (int i = 0; i < 20; i++) begin cycles(1); n += monD; end
      `CHK({n, bitCount}, {32'd0, 8'd140})
   endtask
   // ----------------------------------------------------------
   // Run control
   // ----------------------------------------------------------
   task automatic final_report();
      $display("checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {rstn, psel, penable, pwrite, frameStart, engineHalt, signValid, clr} = 8'h00;
      paddr = 16'h0; pwdata = 32'h0; signBits = 2'b00; auxBits = 2'b00;
      mismatches = 0; samples_checked = 0;
      cycles(16);
      rstn <= 1'b1;
      cycles(2);
      t_regs(); t_bypass(); t_fifo(); t_events(); t_monitor();
      final_report();
   end
   // Whole run is well under a thousand cycles; this is far beyond it
   initial begin
      #100000;
      mismatches++;
      final_report();
   end
endmodule
